// ===== ivpm_entry_model.sv
// exception entry: latches the vector fetch address
`timescale 1ns/10ps
`default_nettype none
module ivpm_entry_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request from the map
  input wire logic irq_valid,
  input wire logic [31:0] irq_vector_addr,
  // fetched vector
  output logic [31:0] fetch_r
);
  // take the vector whenever a request is shown
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fetch_r <= 32'h0;
    else if (irq_valid)
      fetch_r <= irq_vector_addr;
  end
endmodule
`default_nettype wire

// ===== ivpm_monitor.sv
// port checks for the interrupt map
`timescale 1ns/10ps
`default_nettype none
module ivpm_monitor #(
  parameter int unsigned PRIO_BITS = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // core side
  input wire logic global_irq_en,
  input wire logic [3:0] core_exc_num,
  input wire logic core_exc_req,
  input wire logic [31:0] table_base,
  // priority access
  input wire logic prio_wr,
  input wire logic [4:0] prio_word_idx,
  input wire logic [31:0] prio_wdata,
  input wire logic [31:0] prio_rdata,
  // request outputs
  input wire logic irq_valid,
  input wire logic irq_is_core,
  input wire logic [6:0] irq_line,
  input wire logic [7:0] irq_prio,
  input wire logic [31:0] irq_vector_addr,
  input wire logic [85:0] line_pending
);
  import ivpm_pkg::*;
  localparam logic [7:0] BM = 8'hff << (8 - PRIO_BITS);
  localparam logic [31:0] WM = {4{BM}};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_core;
    core_exc_req && core_exc_num != 4'h0 |=> irq_valid && irq_is_core && irq_prio == 8'h0
      && irq_vector_addr == $past(table_base) + {$past(core_exc_num), 2'b00};
  endproperty
  a_core: assert property (p_core) else $error("core vector");
  property p_vec;
    irq_valid && !irq_is_core |-> irq_vector_addr == $past(table_base) + 32'h40 + {irq_line, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("line vector");
  property p_rsv;
    (line_pending & ~IVPM_LINE_USED) == 86'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved line");
  property p_low;
    (prio_rdata & ~WM) == 32'h0;
  endproperty
  a_low: assert property (p_low) else $error("low prio bits");
  property p_wr;
    prio_wr && prio_word_idx < 5'd22 ##1 !prio_wr && $stable(prio_word_idx)
      |=> prio_rdata == ($past(prio_wdata, 2) & WM);
  endproperty
  a_wr: assert property (p_wr) else $error("word write");
  property p_ref;
    prio_word_idx >= 5'd22 |=> prio_rdata == 32'h0;
  endproperty
  a_ref: assert property (p_ref) else $error("bad word");
  property p_gate;
    !global_irq_en && !(core_exc_req && core_exc_num != 4'h0) |=> !irq_valid;
  endproperty
  a_gate: assert property (p_gate) else $error("global gate");
  property p_win;
    irq_valid && !irq_is_core |-> line_pending[irq_line];
  endproperty
  a_win: assert property (p_win) else $error("winner");
endmodule
bind ivpm_top ivpm_monitor #(.PRIO_BITS(PRIO_BITS)) ivpm_monitor_inst (.ref_clk, .rst,
  .global_irq_en, .core_exc_num, .core_exc_req, .table_base, .prio_wr, .prio_word_idx,
  .prio_wdata, .prio_rdata, .irq_valid, .irq_is_core, .irq_line, .irq_prio, .irq_vector_addr,
  .line_pending);
`default_nettype wire

// ===== ivpm_pkg.sv
// constants shared by the interrupt vector and priority map
package ivpm_pkg;
  localparam int unsigned IVPM_LINES = 86;
  localparam int unsigned IVPM_LINE_W = 7;
  localparam int unsigned IVPM_PRIO_BYTE_W = 8;
  localparam int unsigned IVPM_PRIO_BITS = 4;
  localparam int unsigned IVPM_PRIO_WORDS = 22;
  localparam int unsigned IVPM_WORD_IDX_W = 5;
  localparam logic [31:0] IVPM_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] IVPM_RESET_ADDR = 32'h0000_0004;
  localparam logic [31:0] IVPM_SYSTICK_ADDR = 32'h0000_003c;
  localparam logic [31:0] IVPM_PERIPH_BASE = 32'h0000_0040;
  localparam logic [31:0] IVPM_LAST_ADDR = 32'h0000_0194;
  localparam logic [31:0] IVPM_PRIO_RESET = 32'h0000_0000;
  // system-tick occupies exception number 15
  localparam logic [3:0] IVPM_EXC_SYSTICK = 4'hf;
  // implemented source lines; reserved numbers stay tied off
  localparam logic [IVPM_LINES-1:0] IVPM_LINE_USED = {
    1'b1, 2'b00, 4'hf, 2'b00, 3'h7, 5'h00, 6'h3f, 1'b0, 2'b11, 2'b00,
    3'h7, 10'h3ff, 2'b00, 7'h7f, 3'h0, 2'b11, 2'b00, 2'b11, 2'b00,
    10'h3ff, 2'b00, 2'b11, 1'b0, 2'b11, 1'b0, 1'b1, 2'b00, 4'hf};
endpackage

// ===== ivpm_prio_if.sv
// carries the priority word access between the top and the priority store
`timescale 1ns/10ps
`default_nettype none
interface ivpm_prio_if;
  logic wr_en;
  logic [ivpm_pkg::IVPM_WORD_IDX_W-1:0] word_idx;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic [ivpm_pkg::IVPM_LINES*8-1:0] prio_flat;
  modport ctl (output wr_en, output word_idx, output wr_data, input rd_data, input prio_flat);
  modport mem (input wr_en, input word_idx, input wr_data, output rd_data, output prio_flat);
endinterface
`default_nettype wire

// ===== ivpm_prio_store.sv
// priority level bytes, four to a word, with registered read data
`timescale 1ns/10ps
`default_nettype none
module ivpm_prio_store #(
  parameter int unsigned PRIO_BITS = ivpm_pkg::IVPM_PRIO_BITS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // word access
  ivpm_prio_if.mem bus
);
  import ivpm_pkg::*;
  localparam int unsigned NB = IVPM_PRIO_WORDS * 4;
  logic [7:0] byte_r [NB];

  // whole-word writes only; low bits of each byte are not stored
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NB; i++)
        byte_r[i] <= 8'h00;
    end
    else if (bus.wr_en && bus.word_idx < IVPM_WORD_IDX_W'(IVPM_PRIO_WORDS))
    begin
      for (int b = 0; b < 4; b++)
        byte_r[4*bus.word_idx+b] <= {bus.wr_data[8*b+7 -: PRIO_BITS], (8-PRIO_BITS)'(0)};
    end
  end

  // registered read of four bytes together
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bus.rd_data <= IVPM_PRIO_RESET;
    else if (bus.word_idx < IVPM_WORD_IDX_W'(IVPM_PRIO_WORDS))
      bus.rd_data <= {byte_r[4*bus.word_idx+3], byte_r[4*bus.word_idx+2],
                      byte_r[4*bus.word_idx+1], byte_r[4*bus.word_idx]};
    else
      bus.rd_data <= 32'h0000_0000;
  end

  // flat view for the arbiter
  always_comb
  begin
    for (int i = 0; i < IVPM_LINES; i++)
      bus.prio_flat[8*i +: 8] = byte_r[i];
  end
endmodule
`default_nettype wire

// ===== ivpm_top.sv
// interrupt vector map, priority store and request selection
`timescale 1ns/10ps
`default_nettype none
module ivpm_top #(
  parameter int unsigned PRIO_BITS = ivpm_pkg::IVPM_PRIO_BITS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // system sources
  input wire logic supply_drop_alert,
  input wire logic system_clock_loss,
  input wire logic fast_crystal_loss,
  input wire logic slow_crystal_loss,
  input wire logic supervision_timer,
  input wire logic [1:0] free_running_timer,
  input wire logic code_flash_ctrl,
  input wire logic data_flash_ctrl,
  input wire logic [9:0] timer,
  input wire logic random_source,
  input wire logic aes_engine,
  // remaining peripheral sources
  input wire logic [1:0] quadrature_decoder,
  input wire logic [6:0] gpio_port,
  input wire logic [4:0] motor_pwm_0,
  input wire logic [4:0] motor_pwm_1,
  input wire logic [2:0] spi,
  input wire logic [1:0] i2c,
  input wire logic [5:0] uart,
  input wire logic [2:0] converter,
  input wire logic [3:0] analog_comparator,
  input wire logic crc_unit,
  // core side controls
  input wire logic global_irq_en,
  input wire logic [ivpm_pkg::IVPM_LINES-1:0] line_en,
  input wire logic [3:0] core_exc_num,
  input wire logic core_exc_req,
  input wire logic [31:0] table_base,
  // priority word access
  input wire logic prio_wr,
  input wire logic [ivpm_pkg::IVPM_WORD_IDX_W-1:0] prio_word_idx,
  input wire logic [31:0] prio_wdata,
  output logic [31:0] prio_rdata,
  // to exception entry
  output logic irq_valid,
  output logic irq_is_core,
  output logic [6:0] irq_line,
  output logic [7:0] irq_prio,
  output logic [31:0] irq_vector_addr,
  output logic [ivpm_pkg::IVPM_LINES-1:0] line_pending
);
  import ivpm_pkg::*;

  ivpm_prio_if pif ();
  logic [IVPM_LINES-1:0] src;
  logic [IVPM_LINES-1:0] active;
  logic best_found;
  logic [6:0] best_line;
  logic [7:0] best_prio;
  logic core_take;
  logic [31:0] core_vec_nxt;
  logic [31:0] line_vec_nxt;

  // ----------------------------------------------------------------
  // source wiring
  // ----------------------------------------------------------------
  // each source lands on its fixed line number; gaps stay low
  always_comb
  begin
    src = '0;
    src[0] = supply_drop_alert;
    src[1] = system_clock_loss;
    src[2] = fast_crystal_loss;
    src[3] = slow_crystal_loss;
    src[6] = supervision_timer;
    src[9:8] = free_running_timer;
    src[11] = code_flash_ctrl;
    src[12] = data_flash_ctrl;
    src[24:15] = timer;
    src[27] = random_source;
    src[28] = aes_engine;
    src[32:31] = quadrature_decoder;
    src[42:36] = gpio_port;
    src[49:45] = motor_pwm_0;
    src[54:50] = motor_pwm_1;
    src[57:55] = spi;
    src[61:60] = i2c;
    src[68:63] = uart;
    src[76:74] = converter;
    src[82:79] = analog_comparator;
    src[85] = crc_unit;
  end

  // reserved lines masked so they can never assert
  assign active = src & IVPM_LINE_USED & line_en & {IVPM_LINES{global_irq_en}};

  // ----------------------------------------------------------------
  // priority store
  // ----------------------------------------------------------------
  // word access passes straight to the store; no byte lanes exist
  assign pif.wr_en = prio_wr;
  assign pif.word_idx = prio_word_idx;
  assign pif.wr_data = prio_wdata;
  assign prio_rdata = pif.rd_data;

  // store keeps four priority bytes per word and a flat copy for the scan
  ivpm_prio_store #(
    .PRIO_BITS(PRIO_BITS)
  ) u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(pif)
  );

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // scan downward so equal priority keeps the lower line
  always_comb
  begin
    best_found = 1'b0;
    best_line = 7'h00;
    best_prio = 8'hff;
    for (int i = IVPM_LINES - 1; i >= 0; i--)
    begin
      if (active[i] && (!best_found || pif.prio_flat[8*i +: 8] <= best_prio))
      begin
        best_found = 1'b1;
        best_line = 7'(i);
        best_prio = pif.prio_flat[8*i +: 8];
      end
    end
  end

  // pending view of gated lines
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      line_pending <= '0;
    else
      line_pending <= active;
  end

  // ----------------------------------------------------------------
  // vector addresses
  // ----------------------------------------------------------------
  // number zero is the stack pointer word, so it never raises an entry
  assign core_take = core_exc_req && (core_exc_num != 4'h0);
  // core exceptions take one word each above the table base
  assign core_vec_nxt = table_base + {26'h0, core_exc_num, 2'b00};
  // peripheral words follow the sixteen core words
  assign line_vec_nxt = table_base + IVPM_PERIPH_BASE + {23'h0, best_line, 2'b00};

  // ----------------------------------------------------------------
  // presented request
  // ----------------------------------------------------------------
  // valid: any core exception other than number zero, else any gated peripheral line
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_valid <= 1'b0;
    else if (core_take)
      irq_valid <= 1'b1;
    else
      irq_valid <= best_found;
  end

  // source kind; core exceptions win over all peripheral lines
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_is_core <= 1'b0;
    else
      irq_is_core <= core_take;
  end

  // winning line number; zero while a core exception is shown
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_line <= 7'h00;
    else if (core_take)
      irq_line <= 7'h00;
    else
      irq_line <= best_line;
  end

  // winning priority byte; core exceptions show level zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_prio <= 8'h00;
    else if (core_take)
      irq_prio <= 8'h00;
    else
      irq_prio <= best_prio;
  end

  // vector fetch address for the entry logic
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_vector_addr <= IVPM_RESET_ADDR;
    else if (core_take)
      irq_vector_addr <= core_vec_nxt;
    else
      irq_vector_addr <= line_vec_nxt;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// bench for the interrupt vector and priority map
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ivpm_pkg::*;
  logic ref_clk = 0, rst = 1, glb = 0, wr = 0, creq = 0, vld, isc;
  logic [3:0] cnum = 0;
  logic [85:0] src = 0, len = '1, pend;
  logic [4:0] idx = 0;
  logic [31:0] wd = 0, rd, base = 32'h2000, vec, fetch;
  logic [6:0] ln;
  logic [7:0] pr;
  int n_mismatch = 0, samples_checked = 0;
  initial forever #20 ref_clk = ~ref_clk;
  ivpm_top #(.PRIO_BITS(4)) ivpm_top_inst (.ref_clk, .rst, .supply_drop_alert(src[0]),
    .system_clock_loss(src[1]), .fast_crystal_loss(src[2]), .slow_crystal_loss(src[3]),
    .supervision_timer(src[6]), .free_running_timer(src[9:8]), .code_flash_ctrl(src[11]),
    .data_flash_ctrl(src[12]), .timer(src[24:15]), .random_source(src[27]),
    .aes_engine(src[28]), .quadrature_decoder(src[32:31]), .gpio_port(src[42:36]),
    .motor_pwm_0(src[49:45]), .motor_pwm_1(src[54:50]), .spi(src[57:55]), .i2c(src[61:60]),
    .uart(src[68:63]), .converter(src[76:74]), .analog_comparator(src[82:79]),
    .crc_unit(src[85]), .global_irq_en(glb), .line_en(len), .core_exc_num(cnum),
    .core_exc_req(creq), .table_base(base), .prio_wr(wr), .prio_word_idx(idx),
    .prio_wdata(wd), .prio_rdata(rd), .irq_valid(vld), .irq_is_core(isc), .irq_line(ln),
    .irq_prio(pr), .irq_vector_addr(vec), .line_pending(pend));
  ivpm_entry_model ivpm_entry_model_inst (.ref_clk, .rst, .irq_valid(vld),
    .irq_vector_addr(vec), .fetch_r(fetch));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic nxt();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic pw(input logic [4:0] i, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1;
    idx <= i;
    wd <= d;
    @(posedge ref_clk);
    wr <= 0;
    nxt();
  endtask
  task automatic t_prio();
    pw(5'd1, 32'hffffffff);
    chk("prio word", 32'hf0f0f0f0, rd);
    pw(5'd22, 32'hffffffff);
    chk("bad word", 32'h0, rd);
    pw(5'd1, 32'h0);
    $display("prio test done");
  endtask
  task automatic t_lines();
    for (int n = 0; n < 86; n++)
    begin
      @(posedge ref_clk);
      src <= 86'h1 << n;
      nxt();
      chk("valid", {31'h0, IVPM_LINE_USED[n]}, {31'h0, vld});
      chk("pending", {31'h0, IVPM_LINE_USED[n]}, {31'h0, pend[n]});
      if (IVPM_LINE_USED[n])
      begin
        chk("line", 32'(n), {25'h0, ln});
        chk("vector", base + 32'h40 + 4 * n, vec);
      end
    end
    $display("line test done");
  endtask
  task automatic t_arb();
    @(posedge ref_clk);
    src <= (86'h1 << 15) | (86'h1 << 63);
    nxt();
    chk("tie", 32'd15, {25'h0, ln});
    pw(5'd3, 32'h40000000);
    chk("low value", 32'd63, {25'h0, ln});
    pw(5'd15, 32'h80000000);
    chk("prio", 32'h40, {24'h0, pr});
    pw(5'd3, 32'h0);
    pw(5'd15, 32'h0);
    @(posedge ref_clk);
    glb <= 0;
    nxt();
    chk("global off", 32'h0, {31'h0, vld});
    @(posedge ref_clk);
    glb <= 1;
    len[15] <= 0;
    len[63] <= 0;
    nxt();
    chk("line off", 32'h0, {31'h0, vld});
    @(posedge ref_clk);
    len <= '1;
    creq <= 1;
    cnum <= 4'hf;
    nxt();
    chk("core", base + 32'h3c, vec);
    chk("core flag", 32'h1, {31'h0, isc});
    nxt();
    chk("fetch", base + 32'h3c, fetch);
    $display("arbitration test done");
  endtask
  task automatic t_reset();
    repeat (10) @(negedge ref_clk);
    chk("reset vector", IVPM_RESET_ADDR, vec);
    chk("reset prio", IVPM_PRIO_RESET, rd);
    chk("reset valid", 32'h0, {31'h0, vld});
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    glb <= 1;
    $display("reset test done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_prio();
    t_lines();
    t_arb();
    report_and_stop();
  end
endmodule
`default_nettype wire
